// [pkg/oeg_pkg.sv]
// oeg_pkg: constants, types and helpers of the output enable gate.
// assumes a single 40 MHz system clock and a synchronous active-low reset.
//
// Contract
// - fault input is active low
// - emergency-stop input is active high
// - motor-disable input is active low
// - one enable gates all data and control outputs
// - select first setting: enabled without stop/fault, pump ignored
// - select second setting: also needs healthy pump
// - route normal: host pin 17 to terminal and pump
// - route alternate: host pin 17 feeds pump only
// - alternate terminal high only when everything is healthy
// - motor disable forces minimum current on current-set terminals
// - driver disable pin never driven
// - step/direction buffered straight through, no isolation
// - stop or fault reported on host status pin 10
// - even data bits direction, odd bits step
package oeg_pkg;

    localparam int unsigned SYS_CLK_HZ    = 40_000_000;
    localparam int unsigned SYS_PERIOD_NS = 25;

    // slowest legal pump square wave and its longest half period
    localparam int unsigned PUMP_MIN_HZ   = 100;
    localparam int unsigned PUMP_HALF_NS  = 1_000_000_000 / (2 * PUMP_MIN_HZ);
    localparam int unsigned PUMP_TIMEOUT_CYC = PUMP_HALF_NS / SYS_PERIOD_NS;

    localparam int unsigned AXES      = 4;
    localparam int unsigned DATA_W    = 2 * AXES;
    localparam int unsigned SYNC_W    = DATA_W + 4 + 3 + AXES + 2;

    // values after reset
    localparam logic OUT_IDLE      = 1'b0;
    localparam logic SYNC_RST      = 1'b0;
    localparam logic PUMP_RST      = 1'b0;
    localparam logic DISABLE_OE    = 1'b0;

    typedef enum logic [1:0] {
        GATE_HOLD = 2'b01,
        GATE_RUN  = 2'b10
    } oeg_gate_t;

    // direction bits sit on the even data lines
    function automatic logic [AXES-1:0] dir_of(input logic [DATA_W-1:0] d);
        logic [AXES-1:0] r;
        r = '0;
        for (int i = 0; i < AXES; i++) begin
            r[i] = d[2*i];
        end
        return r;
    endfunction

    // step bits sit on the odd data lines
    function automatic logic [AXES-1:0] step_of(input logic [DATA_W-1:0] d);
        logic [AXES-1:0] r;
        r = '0;
        for (int i = 0; i < AXES; i++) begin
            r[i] = d[2*i+1];
        end
        return r;
    endfunction

endpackage

// [rtl/oeg_output_gate.sv]
// oeg_output_gate: safety gate between host port and motor drivers.
// assumes all inputs are asynchronous pins; every output is registered.
`timescale 1ns/1ps
module oeg_output_gate
    import oeg_pkg::*;
#(
    parameter int unsigned PUMP_TIMEOUT = PUMP_TIMEOUT_CYC
) (
    input  wire logic              sys_clk_in,          // 40 MHz clock
    input  wire logic              rstn_in,             // sync reset
    input  wire logic [DATA_W-1:0] host_data_in,        // host data bus
    input  wire logic              host_strobe_in,      // host pin 1
    input  wire logic              host_autofeed_in,    // host pin 14
    input  wire logic              host_init_in,        // host pin 16
    input  wire logic              host_pin17_in,       // host pin 17
    input  wire logic              fault_in_n,          // fault, low
    input  wire logic              estop_in,            // e-stop, high
    input  wire logic              motor_off_in_n,      // motor off, low
    input  wire logic [AXES-1:0]   drv_error_in,        // driver errors
    input  wire logic              enable_select_jumper_in, // 1: pump
    input  wire logic              pin17_route_jumper_in,   // 1: alt
    output logic [AXES-1:0]        drv_dir_out,         // direction
    output logic [AXES-1:0]        drv_step_out,        // step
    output logic                   ctl_strobe_out,      // terminal 1
    output logic                   ctl_autofeed_out,    // terminal 14
    output logic                   ctl_init_out,        // terminal 16
    output logic                   ctl_pin17_out,       // terminal 17
    output logic                   outputs_enabled_out, // gate open
    output logic                   host_stop_out,       // status pin 10
    output logic                   pump_healthy_out,    // pump ok
    output logic [AXES-1:0]        rset_min_out,        // min current
    output logic [AXES-1:0]        drv_disable_oe_out   // disable pin oe
);

    // synchronised pin levels
    logic [SYNC_W-1:0] raw_s;
    logic [SYNC_W-1:0] syn_s;
    logic [DATA_W-1:0] s_data;
    logic              s_strobe;
    logic              s_autofeed;
    logic              s_init;
    logic              s_pin17;
    logic              s_fault_n;
    logic              s_estop;
    logic              s_motor_off_n;
    logic [AXES-1:0]   s_err;
    logic              s_sel;
    logic              s_route;
    logic              pump_ok;

    assign raw_s = {host_data_in, host_strobe_in, host_autofeed_in,
                    host_init_in, host_pin17_in, fault_in_n, estop_in,
                    motor_off_in_n, drv_error_in,
                    enable_select_jumper_in, pin17_route_jumper_in};

    assign {s_data, s_strobe, s_autofeed, s_init, s_pin17, s_fault_n,
            s_estop, s_motor_off_n, s_err, s_sel, s_route} = syn_s;

    // one wide synchroniser; bits are independent levels,
    // so skew between them lasts at most one cycle
    oeg_sync #(
        .W (SYNC_W)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   (raw_s),
        .sync_out   (syn_s)
    );

    // pump always sees host pin 17, whatever the route jumper says
    oeg_pump_watch #(
        .TIMEOUT_CYC (PUMP_TIMEOUT)
    ) u_pump (
        .sys_clk_in  (sys_clk_in),
        .rstn_in     (rstn_in),
        .pin_in      (s_pin17),
        .healthy_out (pump_ok)
    );

    // enable state
    oeg_gate_t gate_q, gate_d;
    logic      stop_s;
    logic      en_s;
    logic      alt_ok_s;

    always_comb begin
        stop_s   = s_estop | ~s_fault_n;
        en_s     = ~stop_s & (~s_sel | pump_ok);
        alt_ok_s = en_s & s_motor_off_n & ~|s_err;
        // motor off and driver errors leave the gate open;
        // they only steer current limit and alternate pin 17
        gate_d   = gate_q;
        unique case (gate_q)
            GATE_HOLD: begin
                if (en_s) begin
                    gate_d = GATE_RUN;
                end
            end
            GATE_RUN: begin
                if (!en_s) begin
                    gate_d = GATE_HOLD;
                end
            end
            default: begin
                gate_d = GATE_HOLD;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            gate_q <= GATE_HOLD;
        end else begin
            gate_q <= gate_d;
        end
    end

    // output state: all registered so the enable edge cannot glitch
    logic [AXES-1:0] dir_q, dir_d;
    logic [AXES-1:0] step_q, step_d;
    logic            strobe_q, strobe_d;
    logic            autofeed_q, autofeed_d;
    logic            init_q, init_d;
    logic            pin17_q, pin17_d;
    logic            en_q, en_d;
    logic            stop_q, stop_d;
    logic            pump_q, pump_d;
    logic [AXES-1:0] rset_q, rset_d;
    logic [AXES-1:0] dis_oe_q, dis_oe_d;

    always_comb begin
        en_d       = en_s;
        dir_d      = {AXES{OUT_IDLE}};
        step_d     = {AXES{OUT_IDLE}};
        strobe_d   = OUT_IDLE;
        autofeed_d = OUT_IDLE;
        init_d     = OUT_IDLE;
        pin17_d    = OUT_IDLE;
        if (en_s) begin
            dir_d      = dir_of(s_data);
            step_d     = step_of(s_data);
            strobe_d   = s_strobe;
            autofeed_d = s_autofeed;
            init_d     = s_init;
            pin17_d    = s_route ? alt_ok_s : s_pin17;
        end
        stop_d   = stop_s;
        pump_d   = pump_ok;
        // current limiting instead of the driver's own disable pin
        rset_d   = {AXES{~s_motor_off_n}};
        dis_oe_d = {AXES{DISABLE_OE}};
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            dir_q      <= {AXES{OUT_IDLE}};
            step_q     <= {AXES{OUT_IDLE}};
            strobe_q   <= OUT_IDLE;
            autofeed_q <= OUT_IDLE;
            init_q     <= OUT_IDLE;
            pin17_q    <= OUT_IDLE;
            en_q       <= OUT_IDLE;
            stop_q     <= OUT_IDLE;
            pump_q     <= OUT_IDLE;
            rset_q     <= {AXES{OUT_IDLE}};
            dis_oe_q   <= {AXES{DISABLE_OE}};
        end else begin
            dir_q      <= dir_d;
            step_q     <= step_d;
            strobe_q   <= strobe_d;
            autofeed_q <= autofeed_d;
            init_q     <= init_d;
            pin17_q    <= pin17_d;
            en_q       <= en_d;
            stop_q     <= stop_d;
            pump_q     <= pump_d;
            rset_q     <= rset_d;
            dis_oe_q   <= dis_oe_d;
        end
    end

    // ports come straight from the flops above
    assign drv_dir_out         = dir_q;
    assign drv_step_out        = step_q;
    assign ctl_strobe_out      = strobe_q;
    assign ctl_autofeed_out    = autofeed_q;
    assign ctl_init_out        = init_q;
    assign ctl_pin17_out       = pin17_q;
    assign outputs_enabled_out = en_q;
    assign host_stop_out       = stop_q;
    assign pump_healthy_out    = pump_q;
    assign rset_min_out        = rset_q;
    assign drv_disable_oe_out  = dis_oe_q;

    // checks: inputs are taken after the synchroniser,
    // so each consequence shows one edge later
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_fault_gates: assert property (
        !s_fault_n |=> !en_q && step_q == '0)
        else $error("fault did not close the gate");

    a_estop_gates: assert property (
        s_estop |=> !en_q && dir_q == '0)
        else $error("e-stop did not close the gate");

    a_motor_rset: assert property (
        !s_motor_off_n |=> rset_q == '1)
        else $error("motor off did not force minimum current");

    a_rset_release: assert property (
        s_motor_off_n [*2] |=> rset_q == '0)
        else $error("minimum current held without motor off");

    a_all_gated: assert property (
        !en_q |-> {dir_q, step_q, strobe_q, autofeed_q, init_q,
                   pin17_q} == '0)
        else $error("output active while gate closed");

    a_first_mode: assert property (
        (!s_sel && !s_estop && s_fault_n) |=> en_q)
        else $error("gate closed in first select setting");

    a_second_mode: assert property (
        (s_sel && !pump_ok) |=> !en_q)
        else $error("gate open without healthy pump");

    a_pin17_normal: assert property (
        !s_route |=> pin17_q == ($past(s_pin17) && en_q))
        else $error("pin 17 not following host");

    a_pin17_alt: assert property (
        (s_route && (!s_motor_off_n || s_err != '0)) |=> !pin17_q)
        else $error("alternate pin 17 high with fault present");

    a_pin17_health: assert property (
        (s_route && s_motor_off_n && s_err == '0) |=> pin17_q == en_q)
        else $error("alternate pin 17 not tracking health");

    a_disable_idle: assert property (
        drv_disable_oe_out == '0 ##1 drv_disable_oe_out == '0)
        else $error("driver disable pin driven");

    a_step_route: assert property (
        en_q |-> step_q == step_of($past(s_data))
               && dir_q == dir_of($past(s_data)))
        else $error("data bits misrouted");

    a_stop_report: assert property (
        (s_estop || !s_fault_n) |=> stop_q)
        else $error("stop not reported to host");

    a_gate_state: assert property (
        en_q |-> gate_q == GATE_RUN)
        else $error("enable and gate state disagree");

    a_stop_clear: assert property (
        (!s_estop && s_fault_n) |=> !stop_q)
        else $error("stop reported without a cause");

    a_second_open: assert property (
        (s_sel && pump_ok && !s_estop && s_fault_n) |=> en_q)
        else $error("gate closed with healthy pump");

    a_ctl_gated: assert property (
        en_q |-> {strobe_q, autofeed_q, init_q}
                 == $past({s_strobe, s_autofeed, s_init}))
        else $error("control outputs not passed through");

    a_err_no_gate: assert property (
        (s_err != '0 && !s_sel && !stop_s) |=> en_q)
        else $error("driver error closed the gate");

    a_motor_no_gate: assert property (
        (!s_motor_off_n && !s_sel && !stop_s) |=> en_q)
        else $error("motor off closed the gate");

    a_rset_in_stop: assert property (
        (!s_motor_off_n && stop_s) |=> rset_q == '1)
        else $error("minimum current lost while stopped");

    a_pin17_stop: assert property (
        (s_route && stop_s) |=> !pin17_q)
        else $error("alternate pin 17 high during stop");

    a_pin17_pump: assert property (
        (s_route && s_sel && !pump_ok) |=> !pin17_q)
        else $error("alternate pin 17 high without pump");

    a_pin17_nopump: assert property (
        (s_route && !s_sel && !stop_s && s_motor_off_n
         && s_err == '0) |=> pin17_q)
        else $error("alternate pin 17 low while healthy");

    // scenarios every run should reach
    c_enabled:   cover property (!en_q ##1 en_q);
    c_pump_mode: cover property (s_sel && pump_ok ##1 en_q);
    c_alt_high:  cover property (s_route ##1 pin17_q);
    c_stop:      cover property (en_q ##1 stop_q);
    c_pump_lost: cover property (pump_ok ##1 !pump_ok);

endmodule // oeg_output_gate

// [rtl/oeg_pump_watch.sv]
// oeg_pump_watch: charge-pump health from edges of host pin 17.
// assumes pin_in is already synchronised to sys_clk_in.
`timescale 1ns/1ps
module oeg_pump_watch
    import oeg_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = PUMP_TIMEOUT_CYC
) (
    input  wire logic sys_clk_in,   // system clock
    input  wire logic rstn_in,      // sync reset, active low
    input  wire logic pin_in,       // synced host pin 17
    output logic      healthy_out   // pump reported healthy
);

    localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] LIM = CW'(TIMEOUT_CYC);

    logic          prev_q, prev_d;
    logic          seen_q, seen_d;
    logic          ok_q, ok_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          edge_s;

    // two edges inside the window are needed; a stuck pin never counts
    always_comb begin
        edge_s = pin_in ^ prev_q;
        prev_d = pin_in;
        seen_d = seen_q;
        ok_d   = ok_q;
        cnt_d  = cnt_q;
        if (edge_s) begin
            cnt_d  = '0;
            seen_d = 1'b1;
            if (seen_q && cnt_q < LIM) begin
                ok_d = 1'b1;
            end
        end else if (cnt_q == LIM) begin
            ok_d   = 1'b0;
            seen_d = 1'b0;
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            prev_q <= PUMP_RST;
            seen_q <= PUMP_RST;
            ok_q   <= PUMP_RST;
            cnt_q  <= '0;
        end else begin
            prev_q <= prev_d;
            seen_q <= seen_d;
            ok_q   <= ok_d;
            cnt_q  <= cnt_d;
        end
    end

    assign healthy_out = ok_q;

endmodule // oeg_pump_watch

// [rtl/oeg_sync.sv]
// oeg_sync: two-flop synchroniser for a vector of independent levels.
// assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
module oeg_sync
    import oeg_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk_in,   // system clock
    input  wire logic         rstn_in,      // sync reset, active low
    input  wire logic [W-1:0] async_in,     // pin levels
    output logic      [W-1:0] sync_out      // synchronised levels
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            meta_q <= {W{SYNC_RST}};
            sync_q <= {W{SYNC_RST}};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // oeg_sync

// [test/oeg_host_model.sv]
// oeg_host_model: host side of pin 17, charge-pump square wave or level.
// assumes run_in and level_in come from the bench on clock edges.
`timescale 1ns/1ps
module oeg_host_model #(
    parameter int unsigned HALF_CYC = 10
) (
    input  wire logic sys_clk_in,   // system clock
    input  wire logic run_in,       // 1: toggle pin 17
    input  wire logic level_in,     // level while stopped
    output logic      pin17_out     // host pin 17
);
    logic        ph_q = 1'b0;
    int unsigned cnt_q = 0;

    // half period far below the shortened pump timeout
    always @(posedge sys_clk_in) begin
        if (!run_in) begin
            cnt_q <= 0;
        end else if (cnt_q == HALF_CYC - 1) begin
            cnt_q <= 0;
            ph_q  <= ~ph_q;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end

    // stopped host drives a static level, never floats
    assign pin17_out = run_in ? ph_q : level_in;
endmodule // oeg_host_model

// [test/tb_top.sv]
// tb_top: self-checking bench for the output enable gate.
// assumes the host model drives pin 17; pump timeout shortened to 50.
`timescale 1ns/1ps
module tb_top;
    import oeg_pkg::*;
    typedef struct {
        logic [AXES-1:0] dir, step, rset;
        logic [2:0]      ctl;
        logic            p17, en, stop, pump, m_p17;
    } oeg_exp_t;

    logic              sys_clk_in = 1'b0;
    logic              rstn_in    = 1'b0;
    logic [DATA_W-1:0] host_data  = '0;
    logic [2:0]        host_ctl   = '0;
    logic              fault_n    = 1'b0;
    logic              estop      = 1'b0;
    logic              motor_off_n = 1'b0;
    logic [AXES-1:0]   drv_err    = '0;
    logic              sel        = 1'b0;
    logic              route      = 1'b0;
    logic              run        = 1'b0;
    logic              lvl        = 1'b0;
    logic              chk        = 1'b0;
    logic              pin17;
    logic [AXES-1:0]   dir_o, step_o, rset_o, dis_o;
    logic              strobe_o, autofeed_o, init_o, p17_o;
    logic              en_o, stop_o, pump_o;
    int                seed       = 32'hb268;
    int                num_errors = 0;
    int                n_compared = 0;
    oeg_exp_t          exp_q[$];
    oeg_exp_t          got;
    oeg_exp_t          zero = '{default: '0};

    always #12.5 sys_clk_in = ~sys_clk_in;

    oeg_host_model host (
        .sys_clk_in (sys_clk_in),
        .run_in     (run),
        .level_in   (lvl),
        .pin17_out  (pin17)
    );

    oeg_output_gate #(.PUMP_TIMEOUT(50)) dut (
        .sys_clk_in              (sys_clk_in),
        .rstn_in                 (rstn_in),
        .host_data_in            (host_data),
        .host_strobe_in          (host_ctl[2]),
        .host_autofeed_in        (host_ctl[1]),
        .host_init_in            (host_ctl[0]),
        .host_pin17_in           (pin17),
        .fault_in_n              (fault_n),
        .estop_in                (estop),
        .motor_off_in_n          (motor_off_n),
        .drv_error_in            (drv_err),
        .enable_select_jumper_in (sel),
        .pin17_route_jumper_in   (route),
        .drv_dir_out             (dir_o),
        .drv_step_out            (step_o),
        .ctl_strobe_out          (strobe_o),
        .ctl_autofeed_out        (autofeed_o),
        .ctl_init_out            (init_o),
        .ctl_pin17_out           (p17_o),
        .outputs_enabled_out     (en_o),
        .host_stop_out           (stop_o),
        .pump_healthy_out        (pump_o),
        .rset_min_out            (rset_o),
        .drv_disable_oe_out      (dis_o)
    );

    task automatic check(input string what, input logic [3:0] seen,
                         input logic [3:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic stop_test();
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // c: {run, route, sel, motor_off_n, fault_n, estop}
    task automatic apply(input logic [5:0] c, input bit rnd_err,
                         input int unsigned wait_cyc);
        logic [31:0] r;
        logic [3:0]  err;
        logic        open;
        oeg_exp_t    e;
        r    = $random(seed);
        err  = rnd_err ? r[15:12] : 4'h0;
        open = !c[0] && c[1] && (!c[3] || c[5]);
        @(posedge sys_clk_in);
        {run, route, sel, motor_off_n, fault_n, estop} <= c;
        {host_data, host_ctl, lvl} <= r[11:0];
        drv_err <= err;
        for (int i = 0; i < AXES; i++) begin
            e.dir[i]  = open & r[4+2*i];
            e.step[i] = open & r[5+2*i];
        end
        e.ctl    = open ? r[3:1] : 3'h0;
        e.p17    = c[4] ? (open && c[2] && err == 4'h0) : (open && r[0]);
        e.m_p17  = !c[4] && c[5];
        e.en     = open;
        e.stop   = c[0] || !c[1];
        e.pump   = c[5];
        e.rset   = {AXES{~c[2]}};
        repeat (wait_cyc) @(posedge sys_clk_in);
        chk <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_in);
        chk <= 1'b0;
    endtask

    always @(negedge sys_clk_in) begin
        if (chk) begin
            got = exp_q.pop_front();
            check("direction", dir_o, got.dir);
            check("step", step_o, got.step);
            check("controls", {1'b0, strobe_o, autofeed_o, init_o},
                  {1'b0, got.ctl});
            check("enabled", 4'(en_o), 4'(got.en));
            check("stop", {3'h0, stop_o}, {3'h0, got.stop});
            check("pump", {3'h0, pump_o}, {3'h0, got.pump});
            if (!got.m_p17)
                check("pin17", 4'(p17_o), 4'(got.p17));
            check("rset_min", rset_o, got.rset);
            check("disable_oe", dis_o, 4'h0);
        end
    end

    initial begin
        repeat (40000) @(posedge sys_clk_in);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (18) @(posedge sys_clk_in);
        chk <= 1'b1;
        exp_q.push_back(zero);
        @(posedge sys_clk_in);
        chk <= 1'b0;
        @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        // long settle covers pump timeout after a run change
        for (int i = 0; i < 128; i++) begin
            apply(i[5:0], i[6], 70);
            apply(i[5:0], i[6], 6);
        end
        stop_test();
    end
endmodule // tb_top
